// ---- mdb_pkg.sv ----
package mdb_pkg;

    // Register offsets
    localparam logic [7:0] OFS_BUS_ADDR = 8'h00;
    localparam logic [7:0] OFS_CTL1     = 8'h01;
    localparam logic [7:0] OFS_CTL2     = 8'h02;
    localparam logic [7:0] OFS_STAT1    = 8'h03;
    localparam logic [7:0] OFS_STAT2    = 8'h04;

    // Reset values
    localparam logic [6:0] BUS_ADDR_RST = 7'h60;
    localparam logic [7:0] CTL1_RST     = 8'h00;
    localparam logic [7:0] CTL2_RST     = 8'h00;
    localparam logic       SLEW_RST     = 1'b0;

    // Writable bits per register
    localparam logic [7:0] BUS_ADDR_WMASK = 8'h7f;
    localparam logic [7:0] CTL1_WMASK     = 8'hff;
    localparam logic [7:0] CTL2_WMASK     = 8'hdf;

    // First control register fields
    localparam int C1_TORQUE = 7;
    localparam int C1_IN_HI  = 6;
    localparam int C1_IN_LO  = 3;
    localparam int C1_SRC    = 2;
    localparam int C1_MODE   = 0;

    // Second control register fields
    localparam int C2_CLEAR  = 7;
    localparam int C2_FLTDIS = 6;
    localparam int C2_DECAY  = 4;
    localparam int C2_OCRESP = 3;
    localparam int C2_OLDMND = 2;
    localparam int C2_OLREPD = 1;
    localparam int C2_OLBRG  = 0;

    // Status one register fields
    localparam int S1_SLEW   = 6;

    // Interface modes
    localparam logic [1:0] MODE_FOUR_PIN = 2'b00;
    localparam logic [1:0] MODE_TWO_PIN  = 2'b01;
    localparam logic [1:0] MODE_PARALLEL = 2'b10;
    localparam logic [1:0] MODE_INDEP    = 2'b11;

    // Bus timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int SCL_QTR_CYC   = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        P_IDLE = 3'b000,
        P_ADDR = 3'b001,
        P_REG  = 3'b011,
        P_WDAT = 3'b010,
        P_RDAT = 3'b110,
        P_IGN  = 3'b100
    } mdb_phase_t;

    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_START = 2'b01,
        H_BYTE  = 2'b11,
        H_STOP  = 2'b10
    } mdb_hstate_t;

endpackage

// ---- mdb_if.sv ----
interface mdb_if;
    logic scl_oe_h;
    logic sda_oe_h;
    logic sda_oe_d;
    logic flt_oe_h;
    logic flt_oe_d;
    logic scl;
    logic sda;
    logic fault_output_pin_n;

    // Open-drain wires with pull-ups
    assign scl                = ~scl_oe_h;
    assign sda                = ~(sda_oe_h | sda_oe_d);
    assign fault_output_pin_n = ~(flt_oe_h | flt_oe_d);

    modport dev (
        input  scl,
        input  sda,
        input  fault_output_pin_n,
        output sda_oe_d,
        output flt_oe_d
    );

    modport host (
        input  scl,
        input  sda,
        input  fault_output_pin_n,
        output scl_oe_h,
        output sda_oe_h,
        output flt_oe_h
    );
endinterface

// ---- mdb_dev.sv ----
// Notes on behaviour
// - Answers at address 0x60 after reset
// - Address register bits 6-0, bit 7 zero
// - Fault disable bit stops fault pin driving
// - Disabled and pin held low: leave bus
// - Host isolates one device, assigns address
// - Host re-enables fault pin, releases pins
// - Sleep reset restores default address
// - Torque bit selects 100 or 50 percent
// - Source bit: pins or register inputs
// - Bits 6-3 are software bridge inputs
// - Two-bit interface mode, resets four-pin
// - Clear command clears faults except open-load
// - Overcurrent: retry or latched shutdown
// - On-demand bit starts open-load detection
// - Report bit suppresses open-load fault signalling
// - Bridge action bit: operate or hi-z
// - Reserved bits zero, unlisted writes avoided
// - Write: address, register, data, stop
// - Read: register write, restart, one byte
// - Status fault bit is the OR of fault flags, open-load only with report bit clear, set even with fault pin disabled
module mdb_dev
    import mdb_pkg::*;
(
    input  wire logic       clk,                       // Clock
    input  wire logic       rst_n,                     // Async reset
    mdb_if.dev              bus,                       // Bus and fault pin
    input  wire logic       sleep_input_n,             // Sleep, resets bank
    input  wire logic [3:0] bridge_pin_in,             // External bridge inputs
    input  wire logic [3:0] overcurrent_evt,           // Overcurrent per output
    input  wire logic [3:0] open_load_evt,             // Open load per output
    input  wire logic       thermal_evt,               // Thermal shutdown
    input  wire logic       undervolt_evt,             // Supply undervoltage
    output logic            torque_half,               // Torque scale 50%
    output logic [3:0]      bridge_in,                 // Selected bridge inputs
    output logic [1:0]      iface_mode,                // Interface mode
    output logic            decay_slow,                // Slow decay
    output logic            overcurrent_response,      // Latched shutdown
    output logic            open_load_on_demand,       // Detection request
    output logic            open_load_report_disable,  // Suppress open-load fault
    output logic            open_load_bridge_action,   // Hi-z on open load
    output logic            slew_select                // Slew rate select
);

    typedef struct packed {
        logic       scl_q;
        logic       sda_q;
        mdb_phase_t ph;
        mdb_phase_t nxt_ph;
        logic       in_ack;
        logic       mack;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic [6:0] act_addr;
        logic       sda_oe;
        logic [6:0] bus_addr;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic       slew;
        logic       oc_f;
        logic       ol_f;
        logic       tsd_f;
        logic       uv_f;
        logic [3:0] oc_out;
        logic [3:0] ol_out;
        logic       fault_oe;
        logic [3:0] bridge_in;
    } mdb_dev_st_t;

    localparam mdb_dev_st_t DEV_RST = '{
        scl_q    : 1'b1,
        sda_q    : 1'b1,
        ph       : P_IDLE,
        nxt_ph   : P_IDLE,
        bus_addr : BUS_ADDR_RST,
        ctl1     : CTL1_RST,
        ctl2     : CTL2_RST,
        slew     : SLEW_RST,
        default  : '0
    };

    mdb_dev_st_t s_r;
    mdb_dev_st_t s_nxt;
    logic        fault_any;
    logic        start_c;
    logic        stop_c;
    logic        rise_c;
    logic        fall_c;
    logic [7:0]  rdata;

    always_comb
    begin
        fault_any = s_r.oc_f | s_r.tsd_f | s_r.uv_f
                  | (s_r.ol_f & ~s_r.ctl2[C2_OLREPD]);
        start_c = s_r.scl_q & bus.scl & s_r.sda_q & ~bus.sda;
        stop_c  = s_r.scl_q & bus.scl & ~s_r.sda_q & bus.sda;
        rise_c  = ~s_r.scl_q & bus.scl;
        fall_c  = s_r.scl_q & ~bus.scl;
        unique case (s_r.ptr)
            OFS_BUS_ADDR: rdata = {1'b0, s_r.bus_addr};
            OFS_CTL1:     rdata = s_r.ctl1;
            OFS_CTL2:     rdata = s_r.ctl2;
            OFS_STAT1:    rdata = {1'b0, s_r.slew, 1'b0, fault_any,
                                   s_r.oc_f, s_r.ol_f, s_r.tsd_f, s_r.uv_f};
            OFS_STAT2:    rdata = {s_r.ol_out, s_r.oc_out};
            default:      rdata = 8'h00;
        endcase
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.scl_q = bus.scl;
        s_nxt.sda_q = bus.sda;
        // Fault flags: a new event wins over the clear
        s_nxt.oc_f   = (s_r.oc_f & ~s_r.ctl2[C2_CLEAR]) | (|overcurrent_evt);
        s_nxt.oc_out = (s_r.oc_out & ~{4{s_r.ctl2[C2_CLEAR]}}) | overcurrent_evt;
        s_nxt.tsd_f  = (s_r.tsd_f & ~s_r.ctl2[C2_CLEAR]) | thermal_evt;
        s_nxt.uv_f   = (s_r.uv_f & ~s_r.ctl2[C2_CLEAR]) | undervolt_evt;
        s_nxt.ol_f   = s_r.ol_f | (|open_load_evt);
        s_nxt.ol_out = s_r.ol_out | open_load_evt;
        s_nxt.ctl2[C2_CLEAR] = 1'b0;
        s_nxt.bridge_in = s_r.ctl1[C1_SRC] ? s_r.ctl1[C1_IN_HI:C1_IN_LO]
                                            : bridge_pin_in;
        s_nxt.fault_oe = fault_any & ~s_r.ctl2[C2_FLTDIS];
        if (start_c)
        begin
            s_nxt.ph       = P_ADDR;
            s_nxt.cnt      = 4'h0;
            s_nxt.in_ack   = 1'b0;
            s_nxt.mack     = 1'b0;
            s_nxt.sda_oe   = 1'b0;
            s_nxt.act_addr = s_r.bus_addr;
        end
        else if (stop_c)
        begin
            s_nxt.ph     = P_IDLE;
            s_nxt.in_ack = 1'b0;
            s_nxt.mack   = 1'b0;
            s_nxt.sda_oe = 1'b0;
        end
        else if (rise_c)
        begin
            if (s_r.mack)
            begin
                if (bus.sda)
                begin
                    s_nxt.ph   = P_IGN;
                    s_nxt.mack = 1'b0;
                end
            end
            else if (!s_r.in_ack && s_r.cnt < 4'h8)
            begin
                unique case (s_r.ph)
                    P_ADDR, P_REG, P_WDAT:
                    begin
                        s_nxt.sh  = {s_r.sh[6:0], bus.sda};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                    P_RDAT:
                    begin
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                    P_IDLE, P_IGN:
                    begin
                        s_nxt.cnt = s_r.cnt;
                    end
                    default:
                    begin
                        s_nxt.ph = P_IDLE;
                    end
                endcase
            end
        end
        else if (fall_c)
        begin
            if (s_r.in_ack)
            begin
                s_nxt.in_ack = 1'b0;
                s_nxt.cnt    = 4'h0;
                s_nxt.ph     = s_r.nxt_ph;
                s_nxt.sda_oe = (s_r.nxt_ph == P_RDAT) & ~s_r.tx[7];
            end
            else if (s_r.mack)
            begin
                // Master acked: send the register again
                s_nxt.mack   = 1'b0;
                s_nxt.cnt    = 4'h0;
                s_nxt.tx     = rdata;
                s_nxt.sda_oe = ~rdata[7];
            end
            else if (s_r.ph == P_RDAT)
            begin
                if (s_r.cnt == 4'h8)
                begin
                    s_nxt.sda_oe = 1'b0;
                    s_nxt.mack   = 1'b1;
                end
                else
                begin
                    s_nxt.sda_oe = ~s_r.tx[3'(7 - s_r.cnt)];
                end
            end
            else if (s_r.cnt == 4'h8)
            begin
                s_nxt.in_ack = 1'b1;
                s_nxt.sda_oe = 1'b1;
                unique case (s_r.ph)
                    P_ADDR:
                    begin
                        if (s_r.sh[7:1] == s_r.act_addr)
                        begin
                            s_nxt.nxt_ph = s_r.sh[0] ? P_RDAT : P_REG;
                            s_nxt.tx     = rdata;
                        end
                        else
                        begin
                            s_nxt.in_ack = 1'b0;
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.ph     = P_IGN;
                        end
                    end
                    P_REG:
                    begin
                        s_nxt.ptr    = s_r.sh;
                        s_nxt.nxt_ph = P_WDAT;
                    end
                    P_WDAT:
                    begin
                        s_nxt.nxt_ph = P_IGN;
                        unique case (s_r.ptr)
                            OFS_BUS_ADDR:
                            begin
                                s_nxt.bus_addr = s_r.sh[6:0];
                            end
                            OFS_CTL1:
                            begin
                                s_nxt.ctl1 = s_r.sh & CTL1_WMASK;
                            end
                            OFS_CTL2:
                            begin
                                s_nxt.ctl2 = s_r.sh & CTL2_WMASK;
                            end
                            OFS_STAT1:
                            begin
                                s_nxt.slew = s_r.sh[S1_SLEW];
                            end
                            default:
                            begin
                                s_nxt.ptr = s_r.ptr;
                            end
                        endcase
                    end
                    default:
                    begin
                        s_nxt.in_ack = 1'b0;
                        s_nxt.sda_oe = 1'b0;
                    end
                endcase
            end
        end
        // Isolated only by a pin pulled low from outside, never by own drive
        if (s_r.ctl2[C2_FLTDIS] && !bus.fault_output_pin_n && !s_r.fault_oe)
        begin
            s_nxt.ph     = P_IDLE;
            s_nxt.in_ack = 1'b0;
            s_nxt.mack   = 1'b0;
            s_nxt.sda_oe = 1'b0;
        end
        if (!sleep_input_n)
        begin
            s_nxt       = DEV_RST;
            s_nxt.scl_q = bus.scl;
            s_nxt.sda_q = bus.sda;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= DEV_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign bus.sda_oe_d              = s_r.sda_oe;
    assign bus.flt_oe_d              = s_r.fault_oe;
    assign torque_half               = s_r.ctl1[C1_TORQUE];
    assign bridge_in                 = s_r.bridge_in;
    assign iface_mode                = s_r.ctl1[C1_MODE +: 2];
    assign decay_slow                = s_r.ctl2[C2_DECAY];
    assign overcurrent_response      = s_r.ctl2[C2_OCRESP];
    assign open_load_on_demand       = s_r.ctl2[C2_OLDMND];
    assign open_load_report_disable  = s_r.ctl2[C2_OLREPD];
    assign open_load_bridge_action   = s_r.ctl2[C2_OLBRG];
    assign slew_select               = s_r.slew;

endmodule // mdb_dev

// ---- mdb_host.sv ----
module mdb_host
    import mdb_pkg::*;
#(
    parameter int QTR_CYC = SCL_QTR_CYC
)
(
    input  wire logic       clk,        // Clock
    input  wire logic       rst_n,      // Async reset
    mdb_if.host             bus,        // Bus and fault pin
    input  wire logic       cmd_valid,  // Request
    output logic            cmd_ready,  // Idle, request taken
    input  wire logic       cmd_read,   // 1 read, 0 write
    input  wire logic [6:0] cmd_dev,    // Device address
    input  wire logic [7:0] cmd_reg,    // Register offset
    input  wire logic [7:0] cmd_wdata,  // Write data
    input  wire logic       isolate,    // Hold fault pin low
    output logic            rsp_valid,  // Done pulse
    output logic [7:0]      rsp_rdata,  // Read data
    output logic            rsp_nack    // Missing acknowledge
);

    if (QTR_CYC < 1 || QTR_CYC > 65535)
    begin : g_chk
        $error("QTR_CYC out of range");
    end

    typedef struct packed {
        mdb_hstate_t st;
        logic [15:0] div;
        logic [1:0]  q;
        logic [3:0]  bc;
        logic [1:0]  bi;
        logic        rd;
        logic [6:0]  dev;
        logic [7:0]  reg_ofs;
        logic [7:0]  wdata;
        logic [7:0]  sh;
        logic        scl_oe;
        logic        sda_oe;
        logic        flt_oe;
        logic        rsp_valid;
        logic [7:0]  rdata;
        logic        nack;
    } mdb_host_st_t;

    localparam mdb_host_st_t HOST_RST = '{st: H_IDLE, default: '0};

    mdb_host_st_t s_r;
    mdb_host_st_t s_nxt;
    logic         tick;
    logic         rdbyte;
    logic [7:0]   nbyte;

    function automatic logic [7:0] byte_for(input mdb_host_st_t s, input logic [1:0] i);
        unique case (i)
            2'd0:    byte_for = {s.dev, 1'b0};
            2'd1:    byte_for = s.reg_ofs;
            2'd2:    byte_for = s.rd ? {s.dev, 1'b1} : s.wdata;
            default: byte_for = 8'hff;
        endcase
    endfunction

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.flt_oe = isolate;
        tick = (s_r.div == 16'(QTR_CYC - 1));
        s_nxt.div = tick ? 16'h0 : s_r.div + 16'h1;
        rdbyte = s_r.rd && (s_r.bi == 2'd3);
        nbyte = byte_for(s_r, s_r.bi + 2'd1);
        if (s_r.st == H_IDLE)
        begin
            if (cmd_valid)
            begin
                s_nxt.st      = H_START;
                s_nxt.q       = 2'd0;
                s_nxt.bi      = 2'd0;
                s_nxt.rd      = cmd_read;
                s_nxt.dev     = cmd_dev;
                s_nxt.reg_ofs = cmd_reg;
                s_nxt.wdata   = cmd_wdata;
                s_nxt.nack    = 1'b0;
                s_nxt.div     = 16'h0;
            end
        end
        else if (tick)
        begin
            s_nxt.q = s_r.q + 2'd1;
            unique case (s_r.st)
                H_START:
                begin
                    unique case (s_r.q)
                        2'd0: s_nxt.sda_oe = 1'b0;
                        2'd1: s_nxt.scl_oe = 1'b0;
                        2'd2: s_nxt.sda_oe = 1'b1;
                        default:
                        begin
                            s_nxt.scl_oe = 1'b1;
                            s_nxt.st     = H_BYTE;
                            s_nxt.bc     = 4'h0;
                            s_nxt.sh     = byte_for(s_r, s_r.bi);
                        end
                    endcase
                end
                H_BYTE:
                begin
                    unique case (s_r.q)
                        2'd0: s_nxt.sda_oe = (s_r.bc < 4'h8) && !rdbyte && !s_r.sh[7];
                        2'd1: s_nxt.scl_oe = 1'b0;
                        2'd2:
                        begin
                            if (s_r.bc < 4'h8)
                            begin
                                s_nxt.sh = {s_r.sh[6:0], bus.sda};
                            end
                        end
                        default:
                        begin
                            s_nxt.scl_oe = 1'b1;
                            s_nxt.bc     = s_r.bc + 4'h1;
                            if (s_r.bc == 4'h8)
                            begin
                                s_nxt.bc = 4'h0;
                                s_nxt.bi = s_r.bi + 2'd1;
                                s_nxt.sh = nbyte;
                                if (!rdbyte && bus.sda)
                                begin
                                    s_nxt.nack = 1'b1;
                                    s_nxt.st   = H_STOP;
                                end
                                else if (rdbyte)
                                begin
                                    s_nxt.rdata = s_r.sh;
                                    s_nxt.st    = H_STOP;
                                end
                                else if (s_r.bi == 2'd1 && s_r.rd)
                                begin
                                    s_nxt.st = H_START;
                                end
                                else if (s_r.bi == 2'd2 && !s_r.rd)
                                begin
                                    s_nxt.st = H_STOP;
                                end
                            end
                        end
                    endcase
                end
                H_STOP:
                begin
                    unique case (s_r.q)
                        2'd0: s_nxt.sda_oe = 1'b1;
                        2'd1: s_nxt.scl_oe = 1'b0;
                        2'd2: s_nxt.sda_oe = 1'b0;
                        default:
                        begin
                            s_nxt.st        = H_IDLE;
                            s_nxt.rsp_valid = 1'b1;
                        end
                    endcase
                end
                default:
                begin
                    s_nxt.st = H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= HOST_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign cmd_ready    = (s_r.st == H_IDLE);
    assign bus.scl_oe_h = s_r.scl_oe;
    assign bus.sda_oe_h = s_r.sda_oe;
    assign bus.flt_oe_h = s_r.flt_oe;
    assign rsp_valid    = s_r.rsp_valid;
    assign rsp_rdata    = s_r.rdata;
    assign rsp_nack     = s_r.nack;

endmodule // mdb_host

// ---- mdb_asserts.sv ----
module mdb_asserts (
    input wire logic clk,                // Clock
    input wire logic rst_n,              // Reset
    input wire logic scl,                // Bus clock
    input wire logic sda,                // Bus data
    input wire logic fault_output_pin_n, // Fault pin
    input wire logic sda_oe_d            // Device data drive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    a_drive_scl_low: assert property ($rose(sda_oe_d) |-> !scl)
        else $error("device drive began with scl high");
    a_sda_held_high: assert property (
        scl && $past(scl) && fault_output_pin_n && $past(fault_output_pin_n) |-> $stable(sda_oe_d))
        else $error("device data changed with scl high");
    a_drive_bounded: assert property ($rose(sda_oe_d) |-> ##[1:200] !sda_oe_d)
        else $error("device drive never released");
    a_start_no_drive: assert property (s_start |-> !sda_oe_d)
        else $error("device driving at start");
    a_stop_released: assert property (s_stop |=> !sda_oe_d[*4])
        else $error("device driving after stop");
    a_scl_low_len: assert property ($fell(scl) |-> !scl[*6])
        else $error("scl low phase too short");
    a_start_then_clock: assert property (s_start |-> ##[2:8] $fell(scl))
        else $error("no clock after start");
    a_stop_idle_gap: assert property (s_stop |=> sda[*8])
        else $error("bus reused too soon after stop");
endmodule // mdb_asserts

// ---- mdb_tb_top.sv ----
module mdb_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, cmd_valid, cmd_ready, cmd_read, isolate, sleep_n, rsp_valid, rsp_nack;
    logic       tq, decay, ocr, odm, olr, olb, slew, tsd, uv;
    logic [1:0] mode;
    logic [3:0] pins, oc, ol, brg;
    logic [6:0] cmd_dev;
    logic [7:0] cmd_reg, cmd_wdata, rsp_rdata;
    int         fails, n_compared;
    mdb_if bus ();
    mdb_dev u_mdb_dev (.clk(clk), .rst_n(rst_n), .bus(bus), .sleep_input_n(sleep_n), .bridge_pin_in(pins),
        .overcurrent_evt(oc), .open_load_evt(ol), .thermal_evt(tsd), .undervolt_evt(uv),
        .torque_half(tq), .bridge_in(brg), .iface_mode(mode), .decay_slow(decay), .overcurrent_response(ocr),
        .open_load_on_demand(odm), .open_load_report_disable(olr), .open_load_bridge_action(olb),
        .slew_select(slew));
    mdb_host #(.QTR_CYC(4)) u_mdb_host (.clk(clk), .rst_n(rst_n), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_dev(cmd_dev), .cmd_reg(cmd_reg),
        .cmd_wdata(cmd_wdata), .isolate(isolate), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_nack(rsp_nack));
    mdb_asserts u_mdb_asserts (.clk(clk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
        .fault_output_pin_n(bus.fault_output_pin_n), .sda_oe_d(bus.sda_oe_d));
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    // One bus command; d is write data or expected read data
    task automatic xfer(input int r, input logic [6:0] a, input logic [7:0] g, input logic [7:0] d,
                        input int k);
        int n;
        cmd_read  <= 1'(r);
        cmd_dev   <= a;
        cmd_reg   <= g;
        cmd_wdata <= d;
        cmd_valid <= 1'b1;
        @(posedge clk);
        while (cmd_ready !== 1'b1)
            @(posedge clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 2000 && rsp_valid !== 1'b1; n++)
            @(posedge clk);
        chk("rsp_valid", 8'h01, {7'h0, rsp_valid});
        chk("nack", {7'h0, k[0]}, {7'h0, rsp_nack});
        if (r != 0 && k == 0)
            chk("rdata", d, rsp_rdata);
    endtask
    task automatic nap();
        sleep_n <= 1'b0;
        repeat (3) @(posedge clk);
        sleep_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_defaults();
        xfer(1, 7'h60, 8'h00, 8'h60, 0);
        xfer(1, 7'h60, 8'h01, 8'h00, 0);
        xfer(1, 7'h60, 8'h07, 8'h00, 0);
        xfer(1, 7'h61, 8'h00, 8'h00, 1);
    endtask
    task automatic t_controls();
        for (int m = 0; m < 4; m++)
        begin
            xfer(0, 7'h60, 8'h01, {5'b11010, 1'b1, m[1:0]}, 0);
            chk("ctl1 outs", {tq, brg, 1'b0, mode}, {5'b11010, 1'b0, m[1:0]});
        end
        pins <= 4'b0110;
        xfer(0, 7'h60, 8'h01, 8'h00, 0);
        chk("pin path", {tq, brg, 3'b0}, 8'h30);
        xfer(0, 7'h60, 8'h02, 8'h3f, 0);
        chk("ctl2 outs", {3'b0, decay, ocr, odm, olr, olb}, 8'h1f);
        xfer(1, 7'h60, 8'h02, 8'h1f, 0);
        xfer(0, 7'h60, 8'h02, 8'h00, 0);
    endtask
    task automatic t_faults();
        {oc, tsd, uv} <= 6'b0100_11;
        @(posedge clk);
        {oc, tsd, uv} <= 6'h00;
        repeat (3) @(posedge clk);
        chk("fault pin", {7'h0, bus.fault_output_pin_n}, 8'h00);
        xfer(1, 7'h60, 8'h03, 8'h1b, 0);
        xfer(1, 7'h60, 8'h04, 8'h04, 0);
        xfer(0, 7'h60, 8'h02, 8'h80, 0);
        xfer(1, 7'h60, 8'h03, 8'h00, 0);
        xfer(1, 7'h60, 8'h02, 8'h00, 0);
        ol <= 4'b0010;
        @(posedge clk);
        ol <= 4'h0;
        xfer(0, 7'h60, 8'h02, 8'h80, 0);
        xfer(1, 7'h60, 8'h04, 8'h20, 0);
        chk("fault pin", {7'h0, bus.fault_output_pin_n}, 8'h00);
        xfer(0, 7'h60, 8'h02, 8'h40, 0);
        chk("fault pin", {7'h0, bus.fault_output_pin_n}, 8'h01);
        xfer(0, 7'h60, 8'h02, 8'h02, 0);
        chk("fault pin", {7'h0, bus.fault_output_pin_n}, 8'h01);
        nap();
    endtask
    task automatic t_address();
        xfer(0, 7'h60, 8'h02, 8'h40, 0);
        isolate <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(1, 7'h60, 8'h00, 8'h60, 1);
        isolate <= 1'b0;
        repeat (3) @(posedge clk);
        xfer(0, 7'h60, 8'h00, 8'ha5, 0);
        xfer(1, 7'h60, 8'h00, 8'h25, 1);
        xfer(1, 7'h25, 8'h00, 8'h25, 0);
        xfer(0, 7'h25, 8'h02, 8'h00, 0);
        nap();
        xfer(1, 7'h60, 8'h00, 8'h60, 0);
        xfer(0, 7'h60, 8'h03, 8'hff, 0);
        xfer(1, 7'h60, 8'h03, 8'h40, 0);
        chk("slew", {7'h0, slew}, 8'h01);
        xfer(0, 7'h60, 8'h04, 8'hff, 0);
        xfer(1, 7'h60, 8'h04, 8'h00, 0);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        {rst_n, cmd_valid, cmd_read, isolate, cmd_dev, cmd_reg, cmd_wdata, pins, oc, ol, tsd, uv} = '0;
        sleep_n = 1'b1;
        fails = 0;
        n_compared = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_defaults();
        t_controls();
        t_faults();
        t_address();
        conclude();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule // mdb_tb_top
